// File: verilog/pph_top.sv
// pulse peak histogrammer: two channels, peak capture, histogram, apb registers
`timescale 1ns/100ps
`default_nettype none
`include "pph_cfg.svh"

module pph_top #(
   parameter int MS_CYCLES = `PPH_MS_NS / `PPH_CLK_NS
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`PPH_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output var  logic [31:0]           prdata,
   output var  logic                  pready,
   output var  logic                  pslverr,
   input  wire pph_pkg::pph_adc_t     adc0,
   input  wire pph_pkg::pph_adc_t     adc1
);
   import pph_pkg::*;

   localparam int CHECK_CYC = `PPH_CHECK_NS / `PPH_CLK_NS;
   localparam int PROC_CYC  = `PPH_PROC_NS / `PPH_CLK_NS;
   localparam int STORE_CYC = PROC_CYC - CHECK_CYC;

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   function automatic logic [`PPH_SAMPLE_W-1:0] trig_level(input logic [`PPH_SAMPLE_W-1:0] thr);
      logic [`PPH_SAMPLE_W+4:0] prod;
      prod = thr * `PPH_TRIG_MUL;
      return prod[`PPH_SAMPLE_W+`PPH_TRIG_SHIFT-1:`PPH_TRIG_SHIFT];
   endfunction : trig_level

   // highest histogram bin for a resolution select; 0 means 14 bits, 5 means 9
   function automatic logic [`PPH_BIN_W-1:0] bin_top(input logic [2:0] res);
      logic [2:0] r;
      r = (res > 3'h5) ? 3'h5 : res;
      return (`PPH_BIN_W'(1) << (`PPH_BIN_W - r)) - `PPH_BIN_W'(`PPH_BIN_TOP_OFF);
   endfunction : bin_top

   function automatic logic [`PPH_BIN_W-1:0] peak_bin(input logic [`PPH_SAMPLE_W-1:0] pk,
                                                       input logic [2:0] res);
      logic [2:0]               r;
      logic [`PPH_SAMPLE_W-1:0] sh;
      r  = (res > 3'h5) ? 3'h5 : res;
      sh = pk >> (`PPH_SAMPLE_W - `PPH_BIN_W + r);
      return sh[`PPH_BIN_W-1:0];
   endfunction : peak_bin

   function automatic logic [31:0] cap_limit(input logic cap32);
      return cap32 ? `PPH_CAP32 : `PPH_CAP16;
   endfunction : cap_limit

   // ----------------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------------
   logic       setup;
   logic       wr_done;
   logic       mem_pend;
   logic [7:0] reg_off;
   logic       ch_sel;
   logic       mem_sel;
   logic       reg_known;

   assign setup   = psel & ~penable;
   assign wr_done = psel & penable & pwrite & pready & ~pslverr;
   assign reg_off = paddr[7:0];
   assign ch_sel  = paddr[`PPH_CH_BIT];
   assign mem_sel = paddr[`PPH_MEM_BIT];

   always_comb
   begin
      case (reg_off)
         `PPH_OFF_CTRL, `PPH_OFF_LOW_THR, `PPH_OFF_WINDOW, `PPH_OFF_RANGE_LO,
         `PPH_OFF_RANGE_HI, `PPH_OFF_PAGE_LIM, `PPH_OFF_TRIG_HI, `PPH_OFF_TRIG_MID,
         `PPH_OFF_TRIG_LO, `PPH_OFF_TIME_HI, `PPH_OFF_TIME_LO, `PPH_OFF_ERR_CNT,
         `PPH_OFF_STATUS: reg_known = 1'b1;
         default:         reg_known = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------------------
   // millisecond tick shared by both channels
   // ----------------------------------------------------------------------------
   logic [31:0] ms_cnt;
   logic        ms_tick;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ms_cnt  <= 32'h0;
         ms_tick <= 1'b0;
      end
      else if (ms_cnt == 32'(MS_CYCLES - 1))
      begin
         ms_cnt  <= 32'h0;
         ms_tick <= 1'b1;
      end
      else
      begin
         ms_cnt  <= ms_cnt + 32'h1;
         ms_tick <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------------------
   pph_adc_t    adc     [0:1];
   logic [31:0] reg_rd  [0:1];
   logic [31:0] host_rd [0:1];

   assign adc[0] = adc0;
   assign adc[1] = adc1;

   for (genvar ch = 0; ch < 2; ch++)
   begin : g_ch
      pph_ctrl_t                ctrl;
      logic [`PPH_SAMPLE_W-1:0] low_thr;
      logic [15:0]              win_len;
      logic [`PPH_BIN_W-1:0]    range_lo;
      logic [`PPH_BIN_W-1:0]    range_hi;
      logic [31:0]              page_lim;
      pph_state_t               state;
      logic [15:0]              cnt;
      logic [`PPH_SAMPLE_W-1:0] prev;
      logic [`PPH_SAMPLE_W-1:0] peak;
      logic                     err;
      logic [`PPH_TRIG_W-1:0]   trig_cnt;
      logic [31:0]              time_ms;
      logic [31:0]              err_cnt;
      logic [`PPH_PAGE_W-1:0]   page;
      logic [31:0]              page_ms;
      logic [31:0]              page_evt;
      logic                     ext_prev;
      logic [`PPH_MEM_AW-1:0]   clr_addr;
      logic                     wr_sel;
      logic                     trig_hit;
      logic [`PPH_BIN_W-1:0]    raw_bin;
      logic [`PPH_BIN_W-1:0]    top;
      logic [`PPH_BIN_W-1:0]    bin;
      logic                     in_range;
      logic                     is_err;
      logic                     store_ok;
      logic                     rmw_step;
      logic                     bin_full;
      logic                     hist_we;
      logic                     ovfl;
      logic                     page_next;
      logic [`PPH_MEM_AW-1:0]   a_addr;
      logic [31:0]              a_rdata;

      assign wr_sel   = wr_done & (ch_sel == 1'(ch)) & ~mem_sel;
      assign trig_hit = (adc[ch].data > trig_level(low_thr))
                        & (prev <= trig_level(low_thr));
      assign top      = bin_top(ctrl.res_sel);
      assign raw_bin  = peak_bin(peak, ctrl.res_sel);
      // out-of-scale peaks land in the top bin; small ones fall into bin 0
      assign bin      = (raw_bin > top) ? top : raw_bin;
      assign in_range = ctrl.range_en ? ((raw_bin >= range_lo) & (raw_bin <= range_hi)
                                         & (raw_bin >= `PPH_BIN_W'(1)) & (raw_bin < top))
                                      : 1'b1;
      assign is_err   = err & ctrl.err_chk;
      assign store_ok = (ctrl.mode == PULSE_HEIGHT_HISTOGRAM_MODE) & in_range & ~is_err;
      assign rmw_step = (state == ST_STORE) & (cnt == 16'h1);
      assign bin_full = a_rdata[31:0] >= cap_limit(ctrl.cap32);
      assign hist_we  = rmw_step & store_ok & ~bin_full;
      assign ovfl     = rmw_step & store_ok & bin_full;
      assign a_addr   = (state == ST_CLEAR) ? clr_addr : {page, bin};
      assign page_next = (wr_sel & (reg_off == `PPH_OFF_CTRL) & pwdata[`PPH_ADV_BIT])
                       | ((ctrl.page_src == PAGE_TIME) & (page_ms >= page_lim))
                       | ((ctrl.page_src == PAGE_COUNT) & (page_evt >= page_lim))
                       | ((ctrl.page_src == PAGE_EXT) & adc[ch].page_ext & ~ext_prev)
                       | ((ctrl.page_src == PAGE_OVFL) & ovfl);

      pph_hist_mem u_mem (
         .clk     (pclk),
         .a_addr  (a_addr),
         .a_we    (hist_we | (state == ST_CLEAR)),
         .a_wdata ((state == ST_CLEAR) ? 32'h0 : a_rdata + 32'h1),
         .a_rdata (a_rdata),
         .b_addr  (paddr[`PPH_MEM_AW+1:2]),
         .b_rdata (host_rd[ch])
      );

      // configuration written by software
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            ctrl     <= '0;
            low_thr  <= `PPH_RST_LOW_THR;
            win_len  <= `PPH_RST_WINDOW;
            range_lo <= '0;
            range_hi <= '0;
            page_lim <= `PPH_RST_PAGE_LIM;
         end
         else if (wr_sel)
         begin
            case (reg_off)
               `PPH_OFF_CTRL:     ctrl     <= pph_ctrl_t'(pwdata[`PPH_CTRL_W-1:0] & ~`PPH_CTRL_PULSE);
               `PPH_OFF_LOW_THR:  low_thr  <= pwdata[`PPH_SAMPLE_W-1:0];
               `PPH_OFF_WINDOW:   win_len  <= pwdata[15:0];
               `PPH_OFF_RANGE_LO: range_lo <= pwdata[`PPH_BIN_W-1:0];
               `PPH_OFF_RANGE_HI: range_hi <= pwdata[`PPH_BIN_W-1:0];
               `PPH_OFF_PAGE_LIM: page_lim <= pwdata;
               default:           ctrl     <= ctrl;
            endcase
         end
      end

      // peak capture sequencer; dead time is window (trigger cycle included) + 180 ns
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            state    <= ST_IDLE;
            cnt      <= 16'h0;
            peak     <= '0;
            err      <= 1'b0;
            clr_addr <= '0;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  if (wr_sel & (reg_off == `PPH_OFF_CTRL) & pwdata[`PPH_CLR_BIT])
                  begin
                     state    <= ST_CLEAR;
                     clr_addr <= '0;
                  end
                  else if (ctrl.run & ~adc[ch].gate & trig_hit)
                  begin
                     state <= ST_WINDOW;
                     peak  <= adc[ch].data;
                     err   <= 1'b0;
                     cnt   <= 16'h1;
                  end
               end
               ST_WINDOW:
               begin
                  if (adc[ch].data > peak)
                  begin
                     peak <= adc[ch].data;
                  end
                  cnt <= cnt + 16'h1;
                  if (cnt >= win_len - 16'h1)
                  begin
                     state <= ST_CHECK;
                     cnt   <= 16'h0;
                  end
               end
               ST_CHECK:
               begin
                  if (adc[ch].data > peak)
                  begin
                     err <= 1'b1;
                  end
                  cnt <= cnt + 16'h1;
                  if (cnt == 16'(CHECK_CYC - 1))
                  begin
                     state <= ST_STORE;
                     cnt   <= 16'h0;
                  end
               end
               ST_STORE:
               begin
                  cnt <= cnt + 16'h1;
                  if (cnt == 16'(STORE_CYC - 1))
                  begin
                     state <= ST_IDLE;
                     cnt   <= 16'h0;
                  end
               end
               ST_CLEAR:
               begin
                  clr_addr <= clr_addr + `PPH_MEM_AW'(1);
                  if (&clr_addr)
                  begin
                     state <= ST_IDLE;
                  end
               end
               default:
               begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end

      // previous sample for crossing detection, external page edge
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            prev     <= '0;
            ext_prev <= 1'b0;
         end
         else
         begin
            prev     <= adc[ch].data;
            ext_prev <= adc[ch].page_ext;
         end
      end

      // trigger, time and error counters
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            trig_cnt <= '0;
            time_ms  <= 32'h0;
            err_cnt  <= 32'h0;
         end
         else if (state == ST_CLEAR)
         begin
            trig_cnt <= '0;
            time_ms  <= 32'h0;
            err_cnt  <= 32'h0;
         end
         else
         begin
            if ((state == ST_IDLE) & ctrl.run & ~adc[ch].gate & trig_hit)
            begin
               trig_cnt <= trig_cnt + `PPH_TRIG_W'(1);
            end
            if (ctrl.run & ms_tick)
            begin
               time_ms <= time_ms + 32'h1;
            end
            if (rmw_step & is_err & (err_cnt < cap_limit(ctrl.cap32)))
            begin
               err_cnt <= err_cnt + 32'h1;
            end
         end
      end

      // histogram paging
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
         begin
            page     <= '0;
            page_ms  <= 32'h0;
            page_evt <= 32'h0;
         end
         else if ((state == ST_CLEAR) | page_next)
         begin
            page     <= (state == ST_CLEAR) ? '0 : page + `PPH_PAGE_W'(1);
            page_ms  <= 32'h0;
            page_evt <= 32'h0;
         end
         else
         begin
            if (ctrl.run & ms_tick)
            begin
               page_ms <= page_ms + 32'h1;
            end
            if (hist_we)
            begin
               page_evt <= page_evt + 32'h1;
            end
         end
      end

      always_comb
      begin
         case (reg_off)
            `PPH_OFF_CTRL:     reg_rd[ch] = 32'(ctrl);
            `PPH_OFF_LOW_THR:  reg_rd[ch] = 32'(low_thr);
            `PPH_OFF_WINDOW:   reg_rd[ch] = 32'(win_len);
            `PPH_OFF_RANGE_LO: reg_rd[ch] = 32'(range_lo);
            `PPH_OFF_RANGE_HI: reg_rd[ch] = 32'(range_hi);
            `PPH_OFF_PAGE_LIM: reg_rd[ch] = page_lim;
            `PPH_OFF_TRIG_HI:  reg_rd[ch] = {24'h0, trig_cnt[39:32]};
            `PPH_OFF_TRIG_MID: reg_rd[ch] = {16'h0, trig_cnt[31:16]};
            `PPH_OFF_TRIG_LO:  reg_rd[ch] = {16'h0, trig_cnt[15:0]};
            `PPH_OFF_TIME_HI:  reg_rd[ch] = {16'h0, time_ms[31:16]};
            `PPH_OFF_TIME_LO:  reg_rd[ch] = {16'h0, time_ms[15:0]};
            `PPH_OFF_ERR_CNT:  reg_rd[ch] = err_cnt;
            `PPH_OFF_STATUS:   reg_rd[ch] = {27'h0, err, (state != ST_IDLE), 1'b0, page};
            default:           reg_rd[ch] = 32'h0;
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // apb answer: registers with no wait state, memory reads one, never stalled by events
   // ----------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata   <= 32'h0;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
         mem_pend <= 1'b0;
      end
      else
      begin
         pready   <= 1'b0;
         mem_pend <= 1'b0;
         if (mem_pend)
         begin
            prdata  <= host_rd[ch_sel];
            pready  <= 1'b1;
            pslverr <= 1'b0;
         end
         else if (setup)
         begin
            if (mem_sel & ~pwrite)
            begin
               // error flag keeps the last answer until this read completes
               mem_pend <= 1'b1;
            end
            else
            begin
               pready  <= 1'b1;
               pslverr <= mem_sel | ~reg_known;
               prdata  <= (pwrite | mem_sel) ? 32'h0 : reg_rd[ch_sel];
            end
         end
      end
   end

endmodule : pph_top
`default_nettype wire

// File: verilog/pph_cfg.svh
// constants of the pulse peak histogrammer: offsets, fields, reset values, timing
`ifndef PPH_CFG_SVH
`define PPH_CFG_SVH

// ----------------------------------------------------------------------------
// widths and sizes
// ----------------------------------------------------------------------------
`define PPH_SAMPLE_W    16
`define PPH_ADDR_W      20
`define PPH_BIN_W       14
`define PPH_PAGE_W      2
`define PPH_MEM_AW      16
`define PPH_MEM_DEPTH   65536
`define PPH_CTRL_W      14
`define PPH_CNT_W       16
`define PPH_TRIG_W      40
`define PPH_BIN_TOP_OFF 7

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PPH_CLK_NS      10
`define PPH_CHECK_NS    100
`define PPH_PROC_NS     180
`define PPH_MS_NS       1000000

// ----------------------------------------------------------------------------
// trigger level about 80 % of the low threshold level: (x * 13) >> 4
// ----------------------------------------------------------------------------
`define PPH_TRIG_MUL    5'd13
`define PPH_TRIG_SHIFT  4

// ----------------------------------------------------------------------------
// address map: bit 19 picks the channel, bit 18 the histogram memory window
// ----------------------------------------------------------------------------
`define PPH_CH_BIT      19
`define PPH_MEM_BIT     18
`define PPH_OFF_CTRL      8'h00
`define PPH_OFF_LOW_THR   8'h04
`define PPH_OFF_WINDOW    8'h08
`define PPH_OFF_RANGE_LO  8'h0c
`define PPH_OFF_RANGE_HI  8'h10
`define PPH_OFF_PAGE_LIM  8'h14
`define PPH_OFF_TRIG_HI   8'h18
`define PPH_OFF_TRIG_MID  8'h1c
`define PPH_OFF_TRIG_LO   8'h20
`define PPH_OFF_TIME_HI   8'h24
`define PPH_OFF_TIME_LO   8'h28
`define PPH_OFF_ERR_CNT   8'h2c
`define PPH_OFF_STATUS    8'h30

// control word: clear and page advance are one-shot bits that never stay stored
`define PPH_CLR_BIT       6
`define PPH_ADV_BIT       7
`define PPH_CTRL_PULSE    14'h00c0

// ----------------------------------------------------------------------------
// reset values and capacity limits
// ----------------------------------------------------------------------------
`define PPH_RST_WINDOW    16'h0010
`define PPH_RST_LOW_THR   16'h0100
`define PPH_RST_PAGE_LIM  32'h0000_03e8
`define PPH_CAP16         32'h0000_ffff
`define PPH_CAP32         32'hffff_ffff

`endif

// File: verilog/pph_pkg.sv
// types shared by the pulse peak histogrammer files
`include "pph_cfg.svh"

package pph_pkg;

   typedef struct packed {
      logic [`PPH_SAMPLE_W-1:0] data;
      logic                     gate;
      logic                     page_ext;
   } pph_adc_t;

   typedef enum logic [1:0] {
      PULSE_HEIGHT_HISTOGRAM_MODE = 2'h0,
      TIME_BINNED_COUNT_MODE      = 2'h1,
      EVENT_LIST_MODE             = 2'h2
   } pph_mode_t;

   typedef enum logic [2:0] {
      PAGE_NONE   = 3'h0,
      PAGE_TIME   = 3'h1,
      PAGE_COUNT  = 3'h2,
      PAGE_EXT    = 3'h3,
      PAGE_OVFL   = 3'h4
   } pph_page_src_t;

   typedef struct packed {
      pph_page_src_t page_src;
      logic [2:0]    res_sel;
      logic          page_adv;
      logic          clear;
      logic          cap32;
      logic          range_en;
      logic          err_chk;
      pph_mode_t     mode;
      logic          run;
   } pph_ctrl_t;

   typedef enum {
      ST_IDLE,
      ST_WINDOW,
      ST_CHECK,
      ST_STORE,
      ST_CLEAR
   } pph_state_t;

endpackage : pph_pkg

// File: verilog/pph_hist_mem.sv
// histogram memory: one read-modify-write port, one read-only host port
`timescale 1ns/100ps
`default_nettype none
`include "pph_cfg.svh"

module pph_hist_mem (
   input  wire logic                   clk,
   input  wire logic [`PPH_MEM_AW-1:0] a_addr,
   input  wire logic                   a_we,
   input  wire logic [31:0]            a_wdata,
   output var  logic [31:0]            a_rdata,
   input  wire logic [`PPH_MEM_AW-1:0] b_addr,
   output var  logic [31:0]            b_rdata
);

   logic [31:0] mem [0:`PPH_MEM_DEPTH-1];

   // the host port never writes, so reads cannot disturb accumulation
   always_ff @(posedge clk)
   begin
      if (a_we)
      begin
         mem[a_addr] <= a_wdata;
      end
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
   end

endmodule : pph_hist_mem
`default_nettype wire

// File: bench/pph_monitor.sv
// bus timing checker bound to the pulse peak histogrammer top
`timescale 1ns/100ps
`default_nettype none
`include "pph_cfg.svh"
module pph_monitor (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [`PPH_ADDR_W-1:0] paddr,
   input wire logic [31:0]            prdata,
   input wire logic                   pready,
   input wire logic                   pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_mem_rd; psel && !penable && paddr[`PPH_MEM_BIT] && !pwrite; endsequence
   sequence s_late; !pready ##1 pready; endsequence
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_reg_answer: assert property (psel && !penable && !paddr[`PPH_MEM_BIT] |=> pready)
      else $error("register answer late");
   a_mem_answer: assert property (s_mem_rd |=> s_late)
      else $error("memory answer timing");
   a_mem_refused: assert property (pready && pwrite && paddr[`PPH_MEM_BIT] |-> pslverr)
      else $error("memory write accepted");
   a_data_hold: assert property (!pready |-> $stable(prdata))
      else $error("read data moved");
   a_err_hold: assert property (!pready |-> $stable(pslverr))
      else $error("error flag moved");
   a_idle_quiet: assert property (!psel |-> !pready)
      else $error("ready while idle");
endmodule : pph_monitor
bind pph_top pph_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
`default_nettype wire

// File: bench/pph_adc_src.sv
// converter sample stream model for one input
`timescale 1ns/100ps
`default_nettype none
module pph_adc_src (
   input  wire logic               pclk,
   input  wire logic               gate,
   output var  pph_pkg::pph_adc_t  adc
);
   import pph_pkg::*;
   int q[$];
   initial adc = '0;
   // one sample every clock, baseline zero between pulses
   always @(posedge pclk)
   begin
      adc.data     <= (q.size() > 0) ? 16'(q.pop_front()) : 16'h0000;
      adc.gate     <= gate;
      adc.page_ext <= 1'b0;
   end
endmodule : pph_adc_src
`default_nettype wire

// File: bench/pulse_peak_histogrammer_bench.sv
// self-checking bench for the pulse peak histogrammer
`timescale 1ns/100ps
`default_nettype none
`include "pph_cfg.svh"
module pulse_peak_histogrammer_bench;
   import pph_pkg::*;
   localparam int W   = 8;
   localparam int LVL = (16'h1000 * 13) >> 4;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, g0;
   logic [19:0] paddr;
   logic [31:0] pwdata, prdata, r;
   pph_adc_t    adc0, adc1;
   int          err_total, check_count, exp_trig, exp_err, seed, n;
   int          hist[int];
   pph_top #(.MS_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc0(adc0), .adc1(adc1));
   pph_adc_src src0 (.pclk(pclk), .gate(g0), .adc(adc0));
   pph_adc_src src1 (.pclk(pclk), .gate(1'b0), .adc(adc1));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task conclude;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task apb(input logic w, input logic [19:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
      if (k == 20)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t bus answer timed out", $time);
         conclude;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task rd(input logic [19:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r, x);
   endtask : rd
   // expected peak, error flag and bin, worked out from the samples
   task shot(input int s[$], input logic g);
      int i, k, pk, er;
      g0 <= g;
      @(posedge pclk);
      src0.q = s;
      i = 0;
      while (i < s.size() && s[i] <= LVL) i++;
      if (!g && i < s.size())
      begin
         pk = 0; er = 0;
         for (k = i; k < i + W && k < s.size(); k++) if (s[k] > pk) pk = s[k];
         for (k = i + W; k < i + W + 10 && k < s.size(); k++) if (s[k] > pk) er = 1;
         exp_trig++;
         if (er) exp_err++;
         else hist[pk >> 2]++;
      end
      repeat (s.size() + 40) @(posedge pclk);
   endtask : shot
   initial
   begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
      g0 = 1'b0; seed = 785; err_total = 0; check_count = 0; exp_trig = 0; exp_err = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd(`PPH_OFF_LOW_THR, 32'h0000_0100);
      rd(`PPH_OFF_WINDOW, 32'h0000_0010);
      apb(1'b0, 20'h000fc, 32'h0);
      chk(32'(e), 32'h1);
      apb(1'b1, 20'h40000, 32'h5);
      chk(32'(e), 32'h1);
      // both memories clear at once to keep the run short
      apb(1'b1, `PPH_OFF_CTRL, 32'h0000_0040);
      apb(1'b1, 20'h80000 | `PPH_OFF_CTRL, 32'h0000_0040);
      n = 0;
      do
      begin
         repeat (200) @(posedge pclk);
         apb(1'b0, `PPH_OFF_STATUS, 32'h0);
      end
      while (r[3] !== 1'b0 && ++n < 500);
      if (n == 500)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t memory clear never ended", $time);
         conclude;
      end
      apb(1'b1, `PPH_OFF_LOW_THR, 32'h0000_1000);
      apb(1'b1, `PPH_OFF_WINDOW, W);
      apb(1'b1, `PPH_OFF_CTRL, 32'h0000_0009);
      shot({0, 'h2000, 'h3000, 0, 'h3800, 'h2000, 0}, 1'b0);
      shot({0, 'h2000, 0, 0, 0, 0, 0, 0, 0, 'h3000}, 1'b0);
      shot({0, 'h2000}, 1'b1);
      repeat (3) shot({0, ($random(seed) & 'h7fff) + 'h1000, 'h0800}, 1'b0);
      rd(`PPH_OFF_TRIG_LO, 32'(exp_trig));
      rd(`PPH_OFF_TRIG_MID, 32'h0);
      rd(`PPH_OFF_TRIG_HI, 32'h0);
      rd(`PPH_OFF_ERR_CNT, 32'(exp_err));
      rd(`PPH_OFF_TIME_HI, 32'h0);
      foreach (hist[b]) rd(20'h40000 | 20'(b << 2), 32'(hist[b]));
      rd(20'h80000 | `PPH_OFF_TRIG_LO, 32'h0);
      // manual page advance: status shows page 1, idle, last event clean
      apb(1'b1, `PPH_OFF_CTRL, 32'h0000_0089);
      rd(`PPH_OFF_STATUS, 32'h0000_0001);
      conclude;
   end
endmodule : pulse_peak_histogrammer_bench
`default_nettype wire
